// ==== hdl/ltq_defines.svh ====
// Purpose: Constants for the lap trigger qualifier.
// Assumes: 20 MHz system clock.
// Notes:   Offsets, reset values and timing counts.
`ifndef LTQ_DEFINES_SVH
`define LTQ_DEFINES_SVH
`define LTQ_CLK_HZ        20000000
`define LTQ_TICK_US       1000
`define LTQ_TICK_CYC      ((`LTQ_CLK_HZ / 1000000) * `LTQ_TICK_US)
`define LTQ_DET_MAIN_MS   16'h000F
`define LTQ_DET_SUB_MS    16'h001E
`define LTQ_LOCK_MS       16'h1388
`define LTQ_MIN_PCT       8'h50
`define LTQ_MAX_PCT       8'h78
`define LTQ_CTRL_RST      6'h11
`define LTQ_THRESH_RST    16'h0800
`define LTQ_A_CTRL        8'h00
`define LTQ_A_THRESH      8'h04
`define LTQ_A_DETM        8'h08
`define LTQ_A_DETS        8'h0C
`define LTQ_A_LOCK        8'h10
`define LTQ_A_MINSPD      8'h14
`define LTQ_A_TRACK       8'h18
`define LTQ_A_PCT         8'h1C
`define LTQ_A_PRESET      8'h20
`define LTQ_A_FRAGLIM     8'h24
`define LTQ_A_CNT         8'h28
`define LTQ_A_STAT        8'h2C
`define LTQ_A_DIST        8'h30
`define LTQ_A_CMD         8'h34
`define LTQ_B_POL         0
`define LTQ_B_DIG         1
`define LTQ_B_GPS         2
`define LTQ_B_SUBEN       3
`define LTQ_B_FORCEN      4
`define LTQ_B_TESTB       5
`endif

// ==== hdl/ltq_pkg.sv ====
// Purpose: Types for the lap trigger qualifier.
// Assumes: Nothing beyond the defines header.
// Notes:   Recording sequencer states.
`default_nettype none
package ltq_pkg;
   typedef enum logic [1:0] {
      LTQ_IDLE, LTQ_RUN, LTQ_CLOSE, LTQ_DOWN
   } ltq_state_e;
endpackage : ltq_pkg
`default_nettype wire

// ==== hdl/ltq_top.sv ====
// Purpose: Lap trigger qualification with lap, outing, fragment counters.
// Assumes: Millisecond tick from a divider; sources synchronised every clock, counted on that tick.
// Notes:   Registers over a plain strobe port, read data one cycle later.
// Functional notes
// - Trigger level comes from any selected measurement source value.
// - Low polarity fires below threshold, high polarity fires above.
// - Main trigger ends a lap; optional sub trigger marks a segment.
// - Sub trigger is disabled when satellite trigger is the source.
// - Main pulse 20 ms low; detection time about 15 ms.
// - Sub pulse 40 ms low; detection time about 30 ms.
// - Triggers are ignored while speed is under the minimum.
// - Triggers are rejected during the lock time after a main trigger.
// - Main triggers are rejected until minimum lap distance is covered.
// - A forced main trigger replaces a missed real one.
// - Threshold applies only to non-digital sources.
// - Satellite trigger input is used only in satellite mode.
// - Counter reset loads stored presets, not zero.
// - After power-on idle; recording starts on global start.
// - Each accepted lap trigger closes a lap and opens a new one.
// - Power loss or start false closes the lap, then shuts down.
// - Outing counts once per power cycle with a real valid lap.
// - Lap counter counts pit exit, trigger to trigger, and forced laps.
// - Fragment counts on test bench, power cycle and size/time limit.
// - Source must stay active for the detection time before firing.
// - Lock time defaults to 5 s; zero disables it.
// - Distance lock holds to a percentage of track; zero disables.
// - Forced trigger at max percentage; new distance starts at excess.
`include "ltq_defines.svh"
`default_nettype none
module ltq_top
   import ltq_pkg::*;
#(
   parameter int TICK_CYC = `LTQ_TICK_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic [15:0] i_src_value,
   input  wire logic        i_src_digital,
   input  wire logic        i_gps_trig,
   input  wire logic [15:0] i_speed,
   input  wire logic [7:0]  i_dist_inc,
   input  wire logic        i_power_ok,
   input  wire logic        i_start_cond,
   input  wire logic        i_frag_size_hit,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   output logic             o_main_trig,
   output logic             o_sub_trig,
   output logic             o_forced,
   output logic             o_recording
);
   // Configuration registers.
   logic [5:0]  ctrl_r;
   logic [15:0] thresh_r, detm_r, dets_r, lock_r, minspd_r;
   logic [23:0] track_r;
   logic [7:0]  minpct_r, maxpct_r;
   logic [15:0] pre_lap_r, pre_frag_r;
   logic [7:0]  pre_out_r;
   logic [15:0] fraglim_r;
   // Runtime state.
   logic [15:0] lap_r, frag_r;
   logic [7:0]  out_r;
   logic [31:0] dist_r;
   logic [15:0] lock_cnt_r, cnt_m_r, cnt_s_r, frag_t_r;
   logic        fired_m_r, fired_s_r, real_lap_r, out_done_r;
   logic        src_m1_r, src_m2_r, src_m3_r, gps1_r, gps2_r, gps3_r;
   logic        first_r, cnt_rst_r;
   logic [31:0] tick_cnt_r;
   logic        tick_r;
   ltq_state_e  st_r;
   logic [31:0] rdata_nxt;

   // Distance limits from the track length and percentages.
   function automatic logic [31:0] pct_of(input logic [23:0] len,
                                          input logic [7:0] pct);
      logic [31:0] prod;
      prod = 32'(len) * 32'(pct);
      return prod / 32'd100;
   endfunction : pct_of

   wire [31:0] min_dist = pct_of(track_r, minpct_r);
   wire [31:0] max_dist = pct_of(track_r, maxpct_r);
   wire gps_mode = ctrl_r[`LTQ_B_GPS];
   wire running  = (st_r == LTQ_RUN);

   // Millisecond tick divider.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b0;
      end else if (tick_cnt_r == 32'(TICK_CYC - 1)) begin
         tick_cnt_r <= 32'h0;
         tick_r     <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
         tick_r     <= 1'b0;
      end
   end

   // Threshold compare; digital sources skip it.
   logic src_act;
   always_comb begin
      if (i_src_digital)
         src_act = (i_src_value[0] == ctrl_r[`LTQ_B_POL]);
      else if (ctrl_r[`LTQ_B_POL])
         src_act = (i_src_value > thresh_r);
      else
         src_act = (i_src_value < thresh_r);
   end

   // Level and pin synchronisers; second and third must agree.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         src_m1_r <= 1'b0;
         src_m2_r <= 1'b0;
         src_m3_r <= 1'b0;
         gps1_r   <= 1'b0;
         gps2_r   <= 1'b0;
         gps3_r   <= 1'b0;
      end else begin
         src_m1_r <= src_act;
         src_m2_r <= src_m1_r;
         src_m3_r <= src_m2_r;
         gps1_r   <= i_gps_trig;
         gps2_r   <= gps1_r;
         gps3_r   <= gps2_r;
      end
   end
   wire src_on  = src_m2_r & src_m3_r;
   wire src_off = ~src_m2_r & ~src_m3_r;

   // Detection filters; main uses detm_r, sub uses the longer dets_r.
   wire det_main = tick_r & src_on & ~fired_m_r & (cnt_m_r + 16'h1 >= detm_r);
   wire det_sub  = tick_r & src_on & ~fired_s_r & (cnt_s_r + 16'h1 >= dets_r)
                   & ctrl_r[`LTQ_B_SUBEN] & ~gps_mode;
   logic gps_q_r;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_m_r   <= 16'h0;
         cnt_s_r   <= 16'h0;
         fired_m_r <= 1'b0;
         fired_s_r <= 1'b0;
         gps_q_r   <= 1'b0;
      end else begin
         gps_q_r <= gps2_r & gps3_r;
         if (src_off) begin
            cnt_m_r   <= 16'h0;
            cnt_s_r   <= 16'h0;
            fired_m_r <= 1'b0;
            fired_s_r <= 1'b0;
         end else if (tick_r && src_on) begin
            if (cnt_m_r != 16'hFFFF) cnt_m_r <= cnt_m_r + 16'h1;
            if (cnt_s_r != 16'hFFFF) cnt_s_r <= cnt_s_r + 16'h1;
            if (det_main) fired_m_r <= 1'b1;
            if (det_sub)  fired_s_r <= 1'b1;
         end
      end
   end

   // Acceptance of a main trigger.
   wire raw_main = gps_mode ? (gps2_r & gps3_r & ~gps_q_r)
                            : det_main;
   wire qual_ok  = (i_speed >= minspd_r)
                 & (lock_cnt_r == 16'h0)
                 & (first_r | minpct_r == 8'h0 |
                    dist_r >= min_dist);
   wire accept   = running & raw_main & qual_ok;
   wire force_tr = running & ~accept & ctrl_r[`LTQ_B_FORCEN]
                 & ~first_r & (dist_r >= max_dist)
                 & (max_dist != 32'h0);
   wire lap_ev   = accept | force_tr;
   wire sub_ok   = running & det_sub & (i_speed >= minspd_r)
                 & (lock_cnt_r == 16'h0);

   // Lock timer, loaded in ticks after each main trigger.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn)
         lock_cnt_r <= 16'h0;
      else if (lap_ev)
         lock_cnt_r <= lock_r;
      else if (tick_r && lock_cnt_r != 16'h0)
         lock_cnt_r <= lock_cnt_r - 16'h1;
   end

   // Lap distance; forced trigger keeps the excess over track.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn)
         dist_r <= 32'h0;
      else if (force_tr)
         dist_r <= dist_r - 32'(track_r);
      else if (accept)
         dist_r <= 32'h0;
      else if (running)
         dist_r <= dist_r + 32'(i_dist_inc);
   end

   // Recording sequencer.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn)
         st_r <= LTQ_IDLE;
      else
         case (st_r)
            LTQ_IDLE: if (i_power_ok && i_start_cond)
               st_r <= LTQ_RUN;
            LTQ_RUN: if (!i_power_ok || !i_start_cond)
               st_r <= LTQ_CLOSE;
            LTQ_CLOSE: st_r <= LTQ_DOWN;
            LTQ_DOWN: if (i_power_ok && i_start_cond)
               st_r <= LTQ_RUN;
            default: st_r <= LTQ_IDLE;
         endcase
   end

   // Lap, outing and fragment counters.
   // Closing a run in test-bench operation opens a new fragment.
   wire frag_bench = ctrl_r[`LTQ_B_TESTB] & (st_r == LTQ_CLOSE);
   wire frag_lim  = running & ((fraglim_r != 16'h0 && tick_r &&
                    frag_t_r + 16'h1 >= fraglim_r) | i_frag_size_hit);
   wire restart   = (st_r == LTQ_DOWN) & i_power_ok & i_start_cond;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lap_r      <= 16'h0;
         out_r      <= 8'h0;
         frag_r     <= 16'h0;
         frag_t_r   <= 16'h0;
         first_r    <= 1'b1;
         real_lap_r <= 1'b0;
         out_done_r <= 1'b0;
      end else if (cnt_rst_r) begin
         lap_r  <= pre_lap_r;
         out_r  <= pre_out_r;
         frag_r <= pre_frag_r;
      end else begin
         if (lap_ev) begin
            lap_r   <= lap_r + 16'h1;
            first_r <= 1'b0;
         end
         if (accept && !first_r)
            real_lap_r <= 1'b1;
         if (real_lap_r && !out_done_r) begin
            out_r      <= out_r + 8'h1;
            out_done_r <= 1'b1;
         end
         frag_t_r <= frag_lim ? 16'h0 :
                     (running && tick_r) ? frag_t_r + 16'h1 : frag_t_r;
         if (frag_lim || restart || frag_bench)
            frag_r <= frag_r + 16'h1;
         if (st_r == LTQ_CLOSE)
            first_r <= 1'b1;
         // A new power cycle must earn its own outing again.
         if (restart) begin
            real_lap_r <= 1'b0;
            out_done_r <= 1'b0;
         end
      end
   end

   // Register writes; command word requests the preset load.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_r     <= `LTQ_CTRL_RST;
         thresh_r   <= `LTQ_THRESH_RST;
         detm_r     <= `LTQ_DET_MAIN_MS;
         dets_r     <= `LTQ_DET_SUB_MS;
         lock_r     <= `LTQ_LOCK_MS;
         minspd_r   <= 16'h0000;
         track_r    <= 24'h000000;
         minpct_r   <= `LTQ_MIN_PCT;
         maxpct_r   <= `LTQ_MAX_PCT;
         pre_lap_r  <= 16'h0;
         pre_out_r  <= 8'h0;
         pre_frag_r <= 16'h0;
         fraglim_r  <= 16'h0;
         cnt_rst_r  <= 1'b0;
      end else begin
         cnt_rst_r <= i_wr && i_addr == `LTQ_A_CMD && i_wdata[0];
         if (i_wr)
            case (i_addr)
               `LTQ_A_CTRL:    ctrl_r    <= i_wdata[5:0];
               `LTQ_A_THRESH:  thresh_r  <= i_wdata[15:0];
               `LTQ_A_DETM:    detm_r    <= i_wdata[15:0];
               `LTQ_A_DETS:    dets_r    <= i_wdata[15:0];
               `LTQ_A_LOCK:    lock_r    <= i_wdata[15:0];
               `LTQ_A_MINSPD:  minspd_r  <= i_wdata[15:0];
               `LTQ_A_TRACK:   track_r   <= i_wdata[23:0];
               `LTQ_A_PCT: begin
                  minpct_r <= i_wdata[7:0];
                  maxpct_r <= i_wdata[15:8];
               end
               `LTQ_A_PRESET: begin
                  pre_lap_r  <= i_wdata[15:0];
                  pre_frag_r <= {8'h00, i_wdata[23:16]};
                  pre_out_r  <= i_wdata[31:24];
               end
               `LTQ_A_FRAGLIM: fraglim_r <= i_wdata[15:0];
               default: ;
            endcase
      end
   end

   // Read mux; lap, outing and low fragment byte are readable, internal timers are not.
   always_comb begin
      case (i_addr)
         `LTQ_A_CTRL:    rdata_nxt = {26'h0, ctrl_r};
         `LTQ_A_THRESH:  rdata_nxt = {16'h0, thresh_r};
         `LTQ_A_DETM:    rdata_nxt = {16'h0, detm_r};
         `LTQ_A_DETS:    rdata_nxt = {16'h0, dets_r};
         `LTQ_A_LOCK:    rdata_nxt = {16'h0, lock_r};
         `LTQ_A_MINSPD:  rdata_nxt = {16'h0, minspd_r};
         `LTQ_A_TRACK:   rdata_nxt = {8'h0, track_r};
         `LTQ_A_PCT:     rdata_nxt = {16'h0, maxpct_r, minpct_r};
         `LTQ_A_PRESET:  rdata_nxt = {pre_out_r, pre_frag_r[7:0], pre_lap_r};
         `LTQ_A_FRAGLIM: rdata_nxt = {16'h0, fraglim_r};
         `LTQ_A_CNT:     rdata_nxt = {out_r, frag_r[7:0], lap_r};
         `LTQ_A_STAT:    rdata_nxt = {26'h0, real_lap_r, o_forced,
                                      first_r, 1'b0, st_r};
         `LTQ_A_DIST:    rdata_nxt = dist_r;
         default:        rdata_nxt = 32'h0;
      endcase
   end

   // Registered outputs.
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata     <= 32'h0;
         o_main_trig <= 1'b0;
         o_sub_trig  <= 1'b0;
         o_forced    <= 1'b0;
         o_recording <= 1'b0;
      end else begin
         o_rdata     <= i_rd ? rdata_nxt : 32'h0;
         o_main_trig <= lap_ev;
         o_sub_trig  <= sub_ok;
         o_forced    <= force_tr;
         o_recording <= running;
      end
   end

   // Assertions.
   main_pulse_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      lap_ev |=> o_main_trig) else $error("main pulse missing");
   lock_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      lap_ev |=> lock_cnt_r == $past(lock_r)) else $error("lock bad");
   speed_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      accept |-> i_speed >= minspd_r) else $error("slow accept");
   gps_sub_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      gps_mode |-> !sub_ok) else $error("sub in gps mode");
   idle_start_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (st_r == LTQ_IDLE && !i_start_cond) |=> st_r == LTQ_IDLE)
      else $error("started early");
   stop_close_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (running && !i_start_cond) |=> st_r == LTQ_CLOSE ##1 st_r == LTQ_DOWN)
      else $error("no close");
   preset_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      cnt_rst_r |=> lap_r == $past(pre_lap_r)) else $error("preset");
   force_flag_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (force_tr && !cnt_rst_r) |=> o_forced && lap_r == $past(lap_r) + 16'h1)
      else $error("forced lap");
   // Once the outing is counted it stays put until the next power cycle.
   out_once_a: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (out_done_r && !cnt_rst_r) |=> $stable(out_r))
      else $error("outing counted twice");
   frag_restart_a: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      (restart && !cnt_rst_r) |=> frag_r == $past(frag_r) + 16'h1)
      else $error("restart fragment missing");
   dist_excess_a: assert property (
      @(posedge i_clk) disable iff (!i_resetn)
      force_tr |=> dist_r == $past(dist_r) - 32'($past(track_r)))
      else $error("forced lap distance");
endmodule : ltq_top
`default_nettype wire

// ==== tb/ltq_beacon_rx.sv ====
// Purpose: Behavioural in-vehicle lap beacon receiver.
// Assumes: Low-active output level; one tick is TICK_CYC clocks.
// Notes:   Idle level follows a changing pattern so no stale value is seen.
`default_nettype none
module ltq_beacon_rx #(
   parameter int TICK_CYC = 4
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_go,
   input  wire logic [7:0]  i_len,
   input  wire logic [15:0] i_idle,
   output logic      [15:0] o_value,
   output logic             o_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;

   // Holds the active level for i_len ticks after each request.
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt <= 0;
      end else if (i_go) begin
         cnt <= int'(i_len) * TICK_CYC;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end

   // A pulse drives a low value; between pulses the level stays high.
   assign o_busy  = (cnt > 0);
   assign o_value = o_busy ? 16'h0100 : i_idle;
endmodule : ltq_beacon_rx
`default_nettype wire

// ==== tb/test_lap_trigger_qualifier.sv ====
// Purpose: Self-checking bench for the lap trigger qualifier.
// Assumes: A tick of 4 clocks, so one millisecond setting is 200 ns.
// Notes:   Counter values are mirrored in integers and compared each step.
`include "ltq_defines.svh"
`default_nettype none
module test_lap_trigger_qualifier;
   import ltq_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 4;
   localparam logic [7:0] RA [6] = '{`LTQ_A_CTRL, `LTQ_A_DETM, `LTQ_A_DETS,
                                     `LTQ_A_LOCK, `LTQ_A_PCT, 8'h3C};
   localparam logic [31:0] RV [6] = '{32'h11, 32'h0F, 32'h1E, 32'h1388,
                                      32'h7850, 32'h0};
   logic        i_clk = 1'b0;
   logic        i_resetn = 1'b0;
   logic [15:0] src;
   logic [15:0] idle = 16'hFFFF;
   logic        i_gps_trig = 1'b0;
   logic        src_dig = 1'b0;
   logic [15:0] i_speed = 16'h0100;
   logic [7:0]  i_dist_inc = 8'h00;
   logic        i_power_ok = 1'b0;
   logic        i_start_cond = 1'b0;
   logic        i_frag_size_hit = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic        o_main_trig;
   logic        o_sub_trig;
   logic        o_forced;
   logic        o_recording;
   logic        go = 1'b0;
   logic [7:0]  len = 8'h00;
   logic        busy;
   logic [31:0] rd;
   logic [31:0] rnd;
   int          seed = 98;
   int          bad_count = 0;
   int          n_tests = 0;
   int          n_main = 0;
   int          n_frc = 0;
   int          n_sub = 0;
   int          e_lap = 7;
   int          e_frag = 5;
   int          e_out = 3;
   int          e_main = 0;

   always #25 i_clk = ~i_clk;

   ltq_top #(.TICK_CYC(TK)) dut_u (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_src_value(src),
      .i_src_digital(src_dig), .i_gps_trig(i_gps_trig), .i_speed(i_speed),
      .i_dist_inc(i_dist_inc), .i_power_ok(i_power_ok),
      .i_start_cond(i_start_cond), .i_frag_size_hit(i_frag_size_hit),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .o_rdata(o_rdata), .o_main_trig(o_main_trig), .o_sub_trig(o_sub_trig),
      .o_forced(o_forced), .o_recording(o_recording));

   ltq_beacon_rx #(.TICK_CYC(TK)) rx_u (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_go(go), .i_len(len),
      .i_idle(idle), .o_value(src), .o_busy(busy));

   // Random idle level above threshold, bit 0 high, and a toggling pin.
   always @(posedge i_clk) begin
      rnd = $random(seed);
      idle <= {1'b1, rnd[14:1], 1'b1};
      i_gps_trig <= rnd[20];
   end

   // Counts trigger pulses seen at the outputs.
   always @(posedge i_clk) begin
      if (o_main_trig === 1'b1) n_main++;
      if (o_forced === 1'b1) n_frc++;
      if (o_sub_trig === 1'b1) n_sub++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      rd = o_rdata;
   endtask : rdr

   task automatic pulse(input logic [7:0] n);
      @(posedge i_clk);
      go <= 1'b1;
      len <= n;
      @(posedge i_clk);
      go <= 1'b0;
      @(posedge i_clk);
      for (int k = 0; k < 1000 && busy === 1'b1; k++) @(posedge i_clk);
      repeat (12) @(posedge i_clk);
   endtask : pulse

   task automatic cnt_chk();
      rdr(`LTQ_A_CNT);
      check(rd, {e_out[7:0], e_frag[7:0], e_lap[15:0]});
      check(32'(n_main), 32'(e_main));
   endtask : cnt_chk

   // Ends the run, closes the lap, cuts power and starts again.
   task automatic cycle_power();
      i_start_cond <= 1'b0;
      for (int k = 0; k < 50 && o_recording !== 1'b0; k++) @(posedge i_clk);
      #1;
      check({31'h0, o_recording}, 32'h0);
      i_power_ok <= 1'b0;
      repeat (20) @(posedge i_clk);
      i_power_ok <= 1'b1;
      i_start_cond <= 1'b1;
      repeat (10) @(posedge i_clk);
      e_frag++;
      rdr(`LTQ_A_CNT);
      check({16'h0, rd[31:16]}, {16'h0, e_out[7:0], e_frag[7:0]});
   endtask : cycle_power

   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   // Watchdog against a hang.
   initial begin
      repeat (40000) @(posedge i_clk);
      bad_count++;
      report_and_stop();
   end

   // Main sequence.
   initial begin
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      wr(8'h3C, 32'hFFFFFFFF);
      #1;
      check({31'h0, o_recording}, 32'h0);
      for (int k = 0; k < 6; k++) begin
         rdr(RA[k]);
         check(rd, RV[k]);
      end
      wr(`LTQ_A_CTRL, 32'h10);
      wr(`LTQ_A_THRESH, 32'h8000);
      wr(`LTQ_A_LOCK, 32'h50);
      wr(`LTQ_A_MINSPD, 32'h10);
      wr(`LTQ_A_TRACK, 32'h3E8);
      wr(`LTQ_A_PRESET, 32'h03050007);
      wr(`LTQ_A_CMD, 32'h1);
      cnt_chk();
      i_power_ok <= 1'b1;
      i_start_cond <= 1'b1;
      repeat (5) @(posedge i_clk);
      #1;
      check({31'h0, o_recording}, 32'h1);
      rdr(`LTQ_A_STAT);
      check({30'h0, rd[1:0]}, {30'h0, LTQ_RUN});
      pulse(8'd10);
      cnt_chk();
      pulse(8'd40);
      e_main = 1;
      e_lap = 8;
      cnt_chk();
      i_dist_inc <= 8'h08;
      repeat (110) @(posedge i_clk);
      i_dist_inc <= 8'h00;
      pulse(8'd20);
      cnt_chk();
      repeat (100) @(posedge i_clk);
      i_speed <= 16'h0000;
      pulse(8'd20);
      cnt_chk();
      i_speed <= 16'h0100;
      pulse(8'd20);
      e_main = 2;
      e_lap = 9;
      e_out = 4;
      cnt_chk();
      repeat (300) @(posedge i_clk);
      pulse(8'd20);
      cnt_chk();
      wr(`LTQ_A_CTRL, 32'h18);
      pulse(8'd40);
      cnt_chk();
      check(32'(n_sub), 32'h1);
      wr(`LTQ_A_CTRL, 32'h1C);
      pulse(8'd40);
      cnt_chk();
      check(32'(n_sub), 32'h1);
      wr(`LTQ_A_CTRL, 32'h10);
      i_dist_inc <= 8'h08;
      for (int k = 0; k < 400 && n_frc == 0; k++) @(posedge i_clk);
      i_dist_inc <= 8'h00;
      repeat (5) @(posedge i_clk);
      check(32'(n_frc), 32'h1);
      e_main = 3;
      e_lap = 10;
      cnt_chk();
      cycle_power();
      src_dig <= 1'b1;
      wr(`LTQ_A_THRESH, 32'h0);
      repeat (300) @(posedge i_clk);
      pulse(8'd20);
      i_dist_inc <= 8'h08;
      repeat (110) @(posedge i_clk);
      i_dist_inc <= 8'h00;
      repeat (250) @(posedge i_clk);
      pulse(8'd20);
      e_main = 5;
      e_lap = 12;
      e_out = 5;
      cnt_chk();
      @(posedge i_clk);
      i_frag_size_hit <= 1'b1;
      @(posedge i_clk);
      i_frag_size_hit <= 1'b0;
      repeat (3) @(posedge i_clk);
      e_frag++;
      rdr(`LTQ_A_CNT);
      check({16'h0, rd[31:16]}, {16'h0, e_out[7:0], e_frag[7:0]});
      cycle_power();
      report_and_stop();
   end
endmodule : test_lap_trigger_qualifier
`default_nettype wire
